/* File: src/rcmc_pkg.sv */
// constants for the routing control message codec
// assumes frames arrive as octets numbered from octet 174, msb-first fields
package rcmc_pkg;
  // ==========================================
  // command codes
  localparam logic [7:0] RCMC_CODE_SET_ROUTE = 8'h31;
  localparam logic [7:0] RCMC_CODE_READ_ROUTE = 8'h33;
  localparam logic [7:0] RCMC_CODE_ROUTE_DATA = 8'h35;
  localparam logic [7:0] RCMC_CODE_MUTE = 8'h41;
  localparam logic [7:0] RCMC_CODE_READ_ATTR = 8'h51;
  localparam logic [7:0] RCMC_CODE_ATTR_VALUE = 8'h53;
  // ==========================================
  // octet positions
  localparam logic [15:0] RCMC_POS_FIRST = 16'h00AE;    // 174
  localparam logic [15:0] RCMC_POS_CODE = 16'h00AF;     // 175
  localparam logic [15:0] RCMC_POS_LEN = 16'h00B0;      // 176
  localparam logic [15:0] RCMC_POS_DEST = 16'h00B2;     // 178
  localparam logic [15:0] RCMC_POS_SRC = 16'h00B4;      // 180
  localparam logic [15:0] RCMC_POS_ZERO_LO = 16'h00B6;  // 182
  localparam logic [15:0] RCMC_POS_ZERO_HI = 16'h00B9;  // 185
  localparam logic [15:0] RCMC_POS_PORT = 16'h00BA;     // 186
  localparam logic [15:0] RCMC_POS_OFFSET = 16'h00BC;   // 188
  localparam logic [15:0] RCMC_POS_LIST = 16'h00BE;     // 190
  localparam logic [15:0] RCMC_POS_ZFILL_HI = 16'h00D9; // 217
  // ==========================================
  // table geometry and reply lengths
  localparam int RCMC_NPORT_W = 2;
  localparam int RCMC_RIDX_W = 6;
  localparam int RCMC_MIDX_W = 1;
  localparam logic [15:0] RCMC_NPORT = 16'h0004;
  localparam logic [15:0] RCMC_RDEPTH = 16'h0040;
  localparam logic [15:0] RCMC_MDEPTH = 16'h0002;
  localparam logic [15:0] RCMC_HDR_LEN = 16'h0004;
  localparam logic [15:0] RCMC_ATTR_LEN = 16'h0004;
  localparam logic [15:0] RCMC_LAST_BASE = 16'h00B9;    // 185
  localparam logic [31:0] RCMC_WORD_RST = 32'h0000_0000;
  // ==========================================
  // states
  typedef enum logic [2:0] {
    RCMC_IDLE = 3'b001,
    RCMC_RECV = 3'b010,
    RCMC_SEND = 3'b100
  } rcmc_state_t;
endpackage

/* File: src/rcmc_field16.sv */
// captures one big-endian 2-octet field at a fixed octet position
// assumes pos is the position of the octet presented with byte_en
`timescale 1ns/1ps
module rcmc_field16 import rcmc_pkg::*; #(
  parameter logic [15:0] POS = 16'h0000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic byte_en,
  input wire logic [15:0] pos,
  input wire logic [7:0] data,
  output logic [15:0] value
);
  logic [15:0] value_r;
  logic [15:0] value_nxt;

  // ==========================================
  // capture
  always_comb begin
    value_nxt = value_r;
    if (clr) begin
      value_nxt = 16'h0000;
    end
    if (byte_en && pos == POS) begin
      value_nxt = {data, value_nxt[7:0]};
    end else if (byte_en && pos == POS + 16'h0001) begin
      value_nxt = {value_r[15:8], data};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      value_r <= 16'h0000;
    end else begin
      value_r <= value_nxt;
    end
  end

  assign value = value_r;
endmodule

/* File: src/rcmc_codec.sv */
// routing, mute and attribute control message codec, device end
// assumes octet streams on clk; rx octets start at frame octet 174
// What this block does
// R1: set-routing message: code 31h, port at 186, offset at 188, records from 190.
// R2: first record goes at the offset, later ones at following positions.
// R3: output port field picks which per-port table a message acts on.
// R4: read request code 33h, port, offset, count; device returns count records.
// R5: routing read answered with code 35h, same layout as the set message.
// R6: mute code 41h, port, offset, 4-octet masks from octet 190.
// R7: read-attribute code 51h, root sub-address at 186, more sub-addresses follow.
// R8: octet 174 zero, code at 175, length 176, addresses 178/180, 182-185 zero.
// R9: record is 2-octet input port then 2-octet input slot, packed.
// R10: attribute read answered with code 53h, value from octet 186.
// R11: unknown command codes are ignored, tables untouched.
`timescale 1ns/1ps
module rcmc_codec import rcmc_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] own_unit_addr,
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [7:0] rx_data,
  input wire logic rx_sof,
  input wire logic rx_eof,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  output logic tx_sof,
  output logic tx_eof,
  output logic attr_req,
  output logic [31:0] attr_addr,
  input wire logic [31:0] attr_value,
  input wire logic [RCMC_NPORT_W-1:0] lk_port,
  input wire logic [RCMC_RIDX_W-1:0] lk_idx,
  output logic [31:0] lk_record,
  output logic lk_muted
);
  localparam int RA_W = RCMC_NPORT_W + RCMC_RIDX_W;
  localparam int MA_W = RCMC_NPORT_W + RCMC_MIDX_W;

  logic [31:0] route_mem [0:(1<<RA_W)-1];
  logic [31:0] mute_mem [0:(1<<MA_W)-1];

  rcmc_state_t state_r, state_nxt;
  logic [15:0] pos_r, pos_nxt, cur_pos;
  logic [7:0] code_r, code_nxt;
  logic bad_r, bad_nxt;
  logic [23:0] acc_r, acc_nxt;
  logic [15:0] txpos_r, txpos_nxt, last_r, last_nxt;
  logic [7:0] tx_data_r, tx_data_nxt;
  logic [7:0] rep_code_r, rep_code_nxt;
  logic attr_req_r, attr_req_nxt;
  logic [31:0] lk_record_r, lk_record_nxt;
  logic lk_muted_r, lk_muted_nxt;
  logic [15:0] f_port, f_offset, f_count, f_src, f_sub1;
  logic take, hdr_clr;
  logic [15:0] rel, widx, tidx, trel, rep_len;
  logic [31:0] word;
  logic route_we, mute_we;
  logic [RA_W-1:0] route_wa;
  logic [MA_W-1:0] mute_wa;
  logic [31:0] rd_word;
  logic [31:0] mute_word;

  assign take = rx_valid && rx_ready;
  assign cur_pos = rx_sof ? RCMC_POS_FIRST : pos_r;
  assign hdr_clr = take && rx_sof;

  // ==========================================
  // header fields
  rcmc_field16 #(.POS(RCMC_POS_PORT)) u_port (.clk(clk), .rst(rst), .clr(hdr_clr),
    .byte_en(take), .pos(cur_pos), .data(rx_data), .value(f_port));
  rcmc_field16 #(.POS(RCMC_POS_OFFSET)) u_offset (.clk(clk), .rst(rst), .clr(hdr_clr),
    .byte_en(take), .pos(cur_pos), .data(rx_data), .value(f_offset));
  rcmc_field16 #(.POS(RCMC_POS_LIST)) u_count (.clk(clk), .rst(rst), .clr(hdr_clr),
    .byte_en(take), .pos(cur_pos), .data(rx_data), .value(f_count));
  rcmc_field16 #(.POS(RCMC_POS_SRC)) u_src (.clk(clk), .rst(rst), .clr(hdr_clr),
    .byte_en(take), .pos(cur_pos), .data(rx_data), .value(f_src));
  rcmc_field16 #(.POS(RCMC_POS_OFFSET)) u_sub1 (.clk(clk), .rst(rst), .clr(hdr_clr),
    .byte_en(take), .pos(cur_pos), .data(rx_data), .value(f_sub1));

  // ==========================================
  // table writes from set-routing and mute lists
  always_comb begin
    rel = cur_pos - RCMC_POS_LIST;
    widx = f_offset + {2'b00, rel[15:2]}; // R2
    word = {acc_r, rx_data}; // R9
    route_we = 1'b0;
    mute_we = 1'b0;
    route_wa = {f_port[RCMC_NPORT_W-1:0], widx[RCMC_RIDX_W-1:0]}; // R3
    mute_wa = {f_port[RCMC_NPORT_W-1:0], widx[RCMC_MIDX_W-1:0]}; // R3
    if (take && !rx_sof && !bad_r && cur_pos >= RCMC_POS_LIST && rel[1:0] == 2'b11
        && f_port < RCMC_NPORT) begin
      route_we = code_r == RCMC_CODE_SET_ROUTE && widx < RCMC_RDEPTH; // R1
      mute_we = code_r == RCMC_CODE_MUTE && widx < RCMC_MDEPTH; // R6
    end
  end

  // memories hold no reset; contents are undefined until loaded
  always_ff @(posedge clk) begin
    if (route_we) begin
      route_mem[route_wa] <= word;
    end
    if (mute_we) begin
      mute_mem[mute_wa] <= word;
    end
  end

  // ==========================================
  // reply octet for a given position
  always_comb begin
    trel = txpos_nxt - RCMC_POS_LIST;
    // full 16-bit subtract, so the high octet sees the borrow
    rep_len = last_nxt - RCMC_LAST_BASE;
    tidx = f_offset + {2'b00, trel[15:2]}; // R4
    rd_word = RCMC_WORD_RST;
    if (tidx < RCMC_RDEPTH && f_port < RCMC_NPORT) begin
      rd_word = route_mem[{f_port[RCMC_NPORT_W-1:0], tidx[RCMC_RIDX_W-1:0]}];
    end
    tx_data_nxt = tx_data_r;
    if (state_nxt == RCMC_SEND) begin
      tx_data_nxt = 8'h00; // R8
      if (txpos_nxt == RCMC_POS_CODE) begin
        tx_data_nxt = rep_code_nxt; // R8
      end else if (txpos_nxt == RCMC_POS_LEN) begin
        tx_data_nxt = rep_len[15:8]; // R8
      end else if (txpos_nxt == RCMC_POS_LEN + 16'h0001) begin
        tx_data_nxt = rep_len[7:0];
      end else if (txpos_nxt == RCMC_POS_DEST) begin
        tx_data_nxt = f_src[15:8];
      end else if (txpos_nxt == RCMC_POS_DEST + 16'h0001) begin
        tx_data_nxt = f_src[7:0];
      end else if (txpos_nxt == RCMC_POS_SRC) begin
        tx_data_nxt = own_unit_addr[15:8];
      end else if (txpos_nxt == RCMC_POS_SRC + 16'h0001) begin
        tx_data_nxt = own_unit_addr[7:0];
      end else if (rep_code_nxt == RCMC_CODE_ATTR_VALUE) begin
        if (txpos_nxt > RCMC_POS_ZERO_HI) begin
          // 186 and 190 share low bits, so value octets follow the record lanes
          unique case (trel[1:0])
            2'b00: tx_data_nxt = attr_value[31:24]; // R10
            2'b01: tx_data_nxt = attr_value[23:16];
            2'b10: tx_data_nxt = attr_value[15:8];
            2'b11: tx_data_nxt = attr_value[7:0];
          endcase
        end
      end else if (txpos_nxt == RCMC_POS_PORT) begin
        tx_data_nxt = f_port[15:8]; // R5
      end else if (txpos_nxt == RCMC_POS_PORT + 16'h0001) begin
        tx_data_nxt = f_port[7:0];
      end else if (txpos_nxt == RCMC_POS_OFFSET) begin
        tx_data_nxt = f_offset[15:8];
      end else if (txpos_nxt == RCMC_POS_OFFSET + 16'h0001) begin
        tx_data_nxt = f_offset[7:0];
      end else if (txpos_nxt >= RCMC_POS_LIST) begin
        unique case (trel[1:0])
          2'b00: tx_data_nxt = rd_word[31:24]; // R9
          2'b01: tx_data_nxt = rd_word[23:16];
          2'b10: tx_data_nxt = rd_word[15:8];
          2'b11: tx_data_nxt = rd_word[7:0];
        endcase
      end
    end
  end

  // ==========================================
  // frame sequencing
  always_comb begin
    state_nxt = state_r;
    pos_nxt = pos_r;
    code_nxt = code_r;
    bad_nxt = bad_r;
    acc_nxt = acc_r;
    txpos_nxt = txpos_r;
    last_nxt = last_r;
    rep_code_nxt = rep_code_r;
    attr_req_nxt = 1'b0;
    if (take) begin
      pos_nxt = cur_pos + 16'h0001;
      acc_nxt = {acc_r[15:0], rx_data};
      if (rx_sof) begin
        state_nxt = RCMC_RECV;
        bad_nxt = rx_data != 8'h00; // R8
        code_nxt = 8'h00;
      end else if (cur_pos == RCMC_POS_CODE) begin
        code_nxt = rx_data; // R8
      end else if (cur_pos >= RCMC_POS_ZERO_LO && cur_pos <= RCMC_POS_ZERO_HI
                   && rx_data != 8'h00) begin
        bad_nxt = 1'b1; // R8
      end else if (code_r == RCMC_CODE_READ_ROUTE && cur_pos > RCMC_POS_LIST + 16'h0001
                   && cur_pos <= RCMC_POS_ZFILL_HI && rx_data != 8'h00) begin
        bad_nxt = 1'b1; // R4
      end
      if (rx_eof) begin
        state_nxt = RCMC_IDLE; // R11
        if (!bad_nxt && code_nxt == RCMC_CODE_READ_ROUTE) begin
          state_nxt = RCMC_SEND; // R4
          rep_code_nxt = RCMC_CODE_ROUTE_DATA; // R5
          last_nxt = RCMC_LAST_BASE + RCMC_HDR_LEN + {f_count[13:0], 2'b00};
          txpos_nxt = RCMC_POS_FIRST;
        end else if (!bad_nxt && code_nxt == RCMC_CODE_READ_ATTR) begin
          state_nxt = RCMC_SEND; // R7
          rep_code_nxt = RCMC_CODE_ATTR_VALUE; // R10
          last_nxt = RCMC_LAST_BASE + RCMC_ATTR_LEN;
          txpos_nxt = RCMC_POS_FIRST;
          attr_req_nxt = 1'b1;
        end
        // any other code just ends the frame
      end
    end else if (state_r == RCMC_SEND && tx_ready) begin
      if (txpos_r == last_r) begin
        state_nxt = RCMC_IDLE;
      end else begin
        txpos_nxt = txpos_r + 16'h0001;
      end
    end
  end

  always_comb begin
    lk_record_nxt = route_mem[{lk_port, lk_idx}];
    mute_word = mute_mem[{lk_port, lk_idx[RCMC_RIDX_W-1 -: RCMC_MIDX_W]}];
    lk_muted_nxt = mute_word[lk_idx[4:0]];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= RCMC_IDLE;
      pos_r <= RCMC_POS_FIRST;
      code_r <= 8'h00;
      bad_r <= 1'b0;
      acc_r <= 24'h000000;
      txpos_r <= RCMC_POS_FIRST;
      last_r <= RCMC_LAST_BASE;
      tx_data_r <= 8'h00;
      rep_code_r <= 8'h00;
      attr_req_r <= 1'b0;
      lk_record_r <= RCMC_WORD_RST;
      lk_muted_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pos_r <= pos_nxt;
      code_r <= code_nxt;
      bad_r <= bad_nxt;
      acc_r <= acc_nxt;
      txpos_r <= txpos_nxt;
      last_r <= last_nxt;
      tx_data_r <= tx_data_nxt;
      rep_code_r <= rep_code_nxt;
      attr_req_r <= attr_req_nxt;
      lk_record_r <= lk_record_nxt;
      lk_muted_r <= lk_muted_nxt;
    end
  end

  // ==========================================
  // outputs; receive stalls while a reply goes out
  assign rx_ready = state_r != RCMC_SEND;
  assign tx_valid = state_r == RCMC_SEND;
  assign tx_data = tx_data_r;
  assign tx_sof = tx_valid && txpos_r == RCMC_POS_FIRST;
  assign tx_eof = tx_valid && txpos_r == last_r;
  assign attr_req = attr_req_r;
  assign attr_addr = {f_port, f_sub1}; // R7
  assign lk_record = lk_record_r;
  assign lk_muted = lk_muted_r;
endmodule

/* File: bench/rcmc_codec_asserts.sv */
// checker on the reply and attribute ports of the codec
// assumes one clock, async active-high reset, bound into rcmc_codec
`timescale 1ns/1ps
module rcmc_codec_asserts import rcmc_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic rx_eof,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_sof,
  input wire logic tx_eof,
  input wire logic attr_req
);
  // ==========================================
  // reply framing
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_take_first;
    tx_valid && tx_ready && tx_sof;
  endsequence
  sequence s_reply_code;
    tx_valid && (tx_data == RCMC_CODE_ROUTE_DATA || tx_data == RCMC_CODE_ATTR_VALUE);
  endsequence
  chk_ready_excl: assert property (rx_ready != tx_valid)
    else $error("rx ready not the inverse of tx valid");
  chk_start_zero: assert property ($rose(tx_valid) |-> tx_sof && tx_data == 8'h00)
    else $error("reply does not open with a zero octet");
  chk_code_follow: assert property (s_take_first |=> s_reply_code)
    else $error("reply code octet wrong");
  chk_hold_stall: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("reply octet changed while stalled");
  chk_eof_close: assert property (tx_valid && tx_ready && tx_eof |=> !tx_valid)
    else $error("reply continues after last octet");
  chk_after_eof: assert property ($rose(tx_valid) |-> $past(rx_eof) && $past(rx_valid))
    else $error("reply started without a request end");
  chk_attr_pulse: assert property (attr_req |=> !attr_req)
    else $error("attribute request longer than one cycle");
  chk_attr_reply: assert property (attr_req |-> tx_valid && !rx_ready)
    else $error("attribute request without reply");
  chk_flag_quiet: assert property (tx_sof || tx_eof |-> tx_valid)
    else $error("reply marker outside a reply");
endmodule

bind rcmc_codec rcmc_codec_asserts chk (.clk, .rst, .rx_valid, .rx_ready, .rx_eof, .tx_valid,
  .tx_ready, .tx_data, .tx_sof, .tx_eof, .attr_req);

/* File: bench/rcmc_sink.sv */
// reply sink standing in for the remote network device
// assumes octets are taken on rising clk edges with valid and ready
`timescale 1ns/1ps
module rcmc_sink (
  input wire logic clk,
  input wire logic slow,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  logic [1:0] tick_r = 2'h0;
  logic [7:0] got[$];
  // slow mode takes one octet in four, to exercise stalls
  assign tx_ready = !slow || (tick_r == 2'h3);
  always @(posedge clk) begin
    tick_r <= tick_r + 2'h1;
    if (tx_valid && tx_ready) got.push_back(tx_data);
  end
endmodule

/* File: bench/testbench.sv */
// self-checking bench for the routing control message codec
// assumes rcmc_pkg, codec, checker and rcmc_sink compiled first
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module testbench import rcmc_pkg::*; ;
  logic clk = 1'h0, rst = 1'h1, rx_valid = 1'h0, rx_sof = 1'h0, rx_eof = 1'h0, slow = 1'h0;
  logic [7:0] rx_data = 8'h00;
  logic [15:0] own = 16'h0C0D;
  logic [31:0] attr_value = 32'h89AB_CDEF;
  logic [RCMC_NPORT_W-1:0] lk_port = '0;
  logic [RCMC_RIDX_W-1:0] lk_idx = '0;
  logic rx_ready, tx_valid, tx_ready, tx_sof, tx_eof, attr_req, lk_muted;
  logic [7:0] tx_data;
  logic [31:0] attr_addr, lk_record;
  logic [7:0] f[$], e[$];
  int mismatches = 0, n_compared = 0, n_req = 0;
  always #2 clk = ~clk;
  always @(posedge clk) if (attr_req === 1'h1) n_req++;
  rcmc_codec uut (.clk(clk), .rst(rst), .own_unit_addr(own), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data), .rx_sof(rx_sof), .rx_eof(rx_eof),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_sof(tx_sof),
    .tx_eof(tx_eof), .attr_req(attr_req), .attr_addr(attr_addr), .attr_value(attr_value),
    .lk_port(lk_port), .lk_idx(lk_idx), .lk_record(lk_record), .lk_muted(lk_muted));
  rcmc_sink sink (.clk(clk), .slow(slow), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready));
  // ==========================================
  // frame helpers
  task automatic hdr(input logic [7:0] code);
    f = '{8'h00, code, 8'h00, 8'h00, 8'h0C, 8'h0D, 8'hAB, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
  endtask
  task automatic w16(input logic [15:0] v);
    f.push_back(v[15:8]);
    f.push_back(v[7:0]);
  endtask
  task automatic send();
    int k = 0;
    foreach (f[i]) begin
      @(negedge clk);
      rx_valid = 1'h1;
      rx_data = f[i];
      rx_sof = (i == 0);
      rx_eof = (i == f.size() - 1);
      // hold the octet while a reply blocks the receive side
      while (rx_ready !== 1'h1 && k < 400) begin
        @(negedge clk);
        k++;
      end
    end
    @(negedge clk);
    rx_valid = 1'h0;
    rx_sof = 1'h0;
    rx_eof = 1'h0;
    if (k == 400) begin
      mismatches++;
      end_of_test();
    end
  endtask
  // muted check skipped when m is x: mute masks are not reset
  task automatic look(input logic [1:0] p, input logic [5:0] x, input logic [31:0] r,
                      input logic m);
    @(negedge clk);
    lk_port = p;
    lk_idx = x;
    @(negedge clk);
    `CHK(lk_record, r)
    if (m !== 1'hx) `CHK(lk_muted, m)
  endtask
  task automatic reply(input int n);
    int k = 0;
    while (sink.got.size() < n && k < 400) begin
      @(negedge clk);
      k++;
    end
    repeat (4) @(negedge clk);
    `CHK(sink.got.size(), n)
    foreach (e[i]) `CHK(sink.got[i], e[i])
    `CHK(rx_ready, 1'h1)
    if (k == 400) begin
      mismatches++;
      end_of_test();
    end
  endtask
  // ==========================================
  // scenarios
  task automatic t_route();
    hdr(RCMC_CODE_SET_ROUTE);
    w16(16'h0001);
    w16(16'h0002);
    w16(16'h0003); w16(16'h0007);
    w16(16'h0002); w16(16'h0011);
    send();
    // last table position, second record falls off the end, partial tail dropped
    hdr(RCMC_CODE_SET_ROUTE);
    w16(16'h0003);
    w16(16'h003F);
    w16(16'h0001); w16(16'h0001);
    w16(16'h0009); w16(16'h0009);
    w16(16'h00EE);
    send();
    look(2'h1, 6'h02, 32'h0003_0007, 1'hx);
    look(2'h1, 6'h03, 32'h0002_0011, 1'hx);
    look(2'h3, 6'h3F, 32'h0001_0001, 1'hx);
  endtask
  task automatic t_mute();
    hdr(RCMC_CODE_MUTE);
    w16(16'h0001);
    w16(16'h0000);
    w16(16'h0000); w16(16'h0004);
    w16(16'h8000); w16(16'h0000);
    send();
    look(2'h1, 6'h02, 32'h0003_0007, 1'h1);
    look(2'h1, 6'h03, 32'h0002_0011, 1'h0);
  endtask
  task automatic t_bad();
    for (int v = 0; v < 3; v++) begin
      hdr(v == 0 ? 8'h37 : RCMC_CODE_SET_ROUTE);
      if (v == 1) f[0] = 8'h01;
      if (v == 2) f[9] = 8'h01;
      w16(16'h0001);
      w16(16'h0002);
      w16(16'hFFFF); w16(16'hFFFF);
      send();
    end
    look(2'h1, 6'h02, 32'h0003_0007, 1'h1);
    sink.got.delete();
    hdr(RCMC_CODE_READ_ROUTE);
    w16(16'h0001); w16(16'h0002); w16(16'h0002);
    repeat (26) f.push_back(8'h00);
    f[30] = 8'h01;
    send();
    repeat (30) @(negedge clk);
    `CHK(sink.got.size(), 0)
  endtask
  task automatic t_read();
    sink.got.delete();
    slow = 1'h1;
    hdr(RCMC_CODE_READ_ROUTE);
    w16(16'h0001); w16(16'h0002); w16(16'h0002);
    repeat (26) f.push_back(8'h00);
    send();
    e = '{8'h00, 8'h35, 8'h00, 8'h0C, 8'hAB, 8'h01, 8'h0C, 8'h0D, 8'h00, 8'h00, 8'h00, 8'h00,
          8'h00, 8'h01, 8'h00, 8'h02, 8'h00, 8'h03, 8'h00, 8'h07, 8'h00, 8'h02, 8'h00, 8'h11};
    reply(24);
    slow = 1'h0;
    // 17 records: length 48h, low octet of the end position wraps below 185
    sink.got.delete();
    f[17] = 8'h11;
    send();
    e = '{8'h00, 8'h35, 8'h00, 8'h48};
    reply(84);
  endtask
  task automatic t_attr();
    sink.got.delete();
    hdr(RCMC_CODE_READ_ATTR);
    w16(16'h1234); w16(16'h5678); w16(16'h9ABC);
    send();
    e = '{8'h00, 8'h53, 8'h00, 8'h04, 8'hAB, 8'h01, 8'h0C, 8'h0D, 8'h00, 8'h00, 8'h00, 8'h00,
          8'h89, 8'hAB, 8'hCD, 8'hEF};
    reply(16);
    `CHK(attr_addr, 32'h1234_5678)
    `CHK(n_req, 1)
  endtask
  task automatic end_of_test();
    if (mismatches == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'h0;
    t_route();
    t_mute();
    t_bad();
    t_read();
    t_attr();
    end_of_test();
  end
endmodule
